// ===== cops_top.sv
// clock output select, port b/c pin function select and peripheral clock gates
// Function
// - source field picks clock pin, zero = system
// - codes route oscillator, pll, converter clocks
// - other low codes are factory test clocks
// - disable bit tri-states the clock pin
// - pb7 carries address 23 or oscillator
// - pb6 carries address 22 or doubled clock
// - pb5 carries address 21 or system clock
// - pb4 carries address 20 or reference clock
// - gpio enable overrides port b choice
// - reserved bits read zero, writes ignored
// - port c choice uses select and timer enable
// - port c selects reset to decoder
// - pc3 decoder home/timer3 or spi select
// - pc2 decoder index/timer2 or spi miso
// - pc1 decoder phase b/timer1 or mosi
// - pc0 decoder phase a/timer0 or sclk
// - per-pin controls, decoder pins input only
// - enable bit gives or withholds peripheral clock
// - one enable bit per peripheral
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module cops_top
  import cops_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // clock sources
  input wire cops_pkg::cops_clk_src_t clk_src,
  // dedicated clock output pin
  output logic clock_output_signal,
  output logic clock_out_pin_oe,
  // port b pins 7..4 (index 3 = pin 7)
  input wire logic [3:0] port_b_peripheral_enable,
  input wire logic [3:0] address_high,
  output logic [3:0] port_b_peripheral_out,
  // port c pins 3..0
  input wire logic [3:0] port_c_peripheral_enable,
  input wire logic [3:0] port_c_pad_in,
  output logic [3:0] port_c_pad_out,
  output logic [3:0] port_c_pad_oe,
  input wire cops_pkg::cops_portc_drive_t portc_drive,
  output cops_pkg::cops_portc_sense_t portc_sense,
  // gated peripheral clocks, bit order as the enable register
  output logic [15:0] periph_clk
);
  import cops_pkg::*;

  // software view of the three registers
  logic [15:0] clk_out_sel_reg;
  logic [15:0] clk_out_sel_next;
  logic [15:0] portc_sel_reg;
  logic [15:0] portc_sel_next;
  logic [15:0] periph_clk_en_reg;
  logic [15:0] periph_clk_en_next;
  // copies that actually steer muxes and gates, one edge behind
  logic [15:0] clk_out_sel_app_reg;
  logic [15:0] portc_sel_app_reg;
  logic [15:0] periph_clk_en_app_reg;
  // bus data phase state
  logic wr_pend_reg;
  logic [5:0] wr_idx_reg;
  logic [31:0] hrdata_reg;
  // pad input synchroniser
  logic [3:0] pad_meta_reg;
  logic [3:0] pad_sync_reg;

  // ------------------------------------------------------------------
  // bus slave: zero wait state, always okay
  // ------------------------------------------------------------------
  wire addr_phase = hsel && hready && htrans[COPS_HTRANS_ACTIVE_BIT];
  wire [5:0] addr_idx = haddr[7:2];
  // writes land in the register at the end of their data phase
  wire wr_clk_out = wr_pend_reg && (wr_idx_reg == COPS_IDX_CLK_OUT_SEL);
  wire wr_portc = wr_pend_reg && (wr_idx_reg == COPS_IDX_PORTC_SEL);
  wire wr_pce = wr_pend_reg && (wr_idx_reg == COPS_IDX_PERIPH_CLK_EN);

  assign clk_out_sel_next = wr_clk_out ? (hwdata[15:0] & COPS_CLK_OUT_SEL_WMASK)
                                       : clk_out_sel_reg;
  assign portc_sel_next = wr_portc ? (hwdata[15:0] & COPS_PORTC_SEL_WMASK)
                                   : portc_sel_reg;
  // one enable bit per peripheral, all writable
  assign periph_clk_en_next = wr_pce ? (hwdata[15:0] & COPS_PERIPH_CLK_EN_WMASK)
                                     : periph_clk_en_reg;

  // read mux looks at next values so a read right behind a write sees it
  wire [15:0] rd_val = (addr_idx == COPS_IDX_CLK_OUT_SEL) ? clk_out_sel_next :
                       (addr_idx == COPS_IDX_PORTC_SEL) ? portc_sel_next :
                       (addr_idx == COPS_IDX_PERIPH_CLK_EN) ? periph_clk_en_next :
                       16'h0000;
  // upper half and unmapped words read as zero
  wire [31:0] rd_word = {16'h0000, rd_val};

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // address phase capture and read data register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 6'h00;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_idx_reg <= addr_idx;
      end
      if (addr_phase && !hwrite) begin
        hrdata_reg <= rd_word;
      end
    end
  end

  // software registers
  // port c selects come out of reset as decoder
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_out_sel_reg <= COPS_CLK_OUT_SEL_RST;
      portc_sel_reg <= COPS_PORTC_SEL_RST;
      periph_clk_en_reg <= COPS_PERIPH_CLK_EN_RST;
    end else begin
      clk_out_sel_reg <= clk_out_sel_next;
      portc_sel_reg <= portc_sel_next;
      periph_clk_en_reg <= periph_clk_en_next;
    end
  end

  // applied copies follow one edge after the write lands
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_out_sel_app_reg <= COPS_CLK_OUT_SEL_RST;
      portc_sel_app_reg <= COPS_PORTC_SEL_RST;
      periph_clk_en_app_reg <= COPS_PERIPH_CLK_EN_RST;
    end else begin
      clk_out_sel_app_reg <= clk_out_sel_reg;
      portc_sel_app_reg <= portc_sel_reg;
      periph_clk_en_app_reg <= periph_clk_en_reg;
    end
  end

  // ------------------------------------------------------------------
  // clock output pin
  // ------------------------------------------------------------------
  wire [4:0] src_code = clk_out_sel_app_reg[COPS_SRC_LSB +: COPS_SRC_W];
  wire clk_out_dis = clk_out_sel_app_reg[COPS_DIS_BIT];
  // test codes index the test clock bundle
  wire test_lo = (src_code >= COPS_SRC_TEST_LO_FIRST) && (src_code <= COPS_SRC_TEST_LO_LAST);
  wire test_hi = (src_code >= COPS_SRC_TEST_HI_FIRST) && (src_code <= COPS_SRC_TEST_HI_LAST);
  wire [3:0] test_lo_idx = src_code[3:0] - COPS_SRC_TEST_LO_FIRST[3:0];
  wire [3:0] test_hi_idx = src_code[3:0] - COPS_SRC_TEST_HI_FIRST[3:0] + COPS_TEST_HI_BASE;
  wire [3:0] test_idx = test_lo ? test_lo_idx : test_hi_idx;
  wire test_clk = clk_src.factory_test_clocks[test_idx];

  // source mux; switching is not glitch-free, so change it with the pin
  // disabled when a clean edge matters to the board
  // zero picks the system clock
  assign clock_output_signal = (src_code == COPS_SRC_SYSTEM) ? clk_src.system_clock :
                               (src_code == COPS_SRC_OSC) ? clk_src.master_oscillator_clock :
                               (src_code == COPS_SRC_PLL) ? clk_src.pll_output_clock :
                               (src_code == COPS_SRC_CONV_A) ? clk_src.converter_a_clock :
                               (src_code == COPS_SRC_CONV_B) ? clk_src.converter_b_clock :
                               (test_lo || test_hi) ? test_clk :
                               1'b0;
  // pad driven only while not disabled
  assign clock_out_pin_oe = !clk_out_dis;

  // ------------------------------------------------------------------
  // port b pins 7..4: address bit or extra clock
  // ------------------------------------------------------------------
  wire [3:0] pb_alt = clk_out_sel_app_reg[COPS_ALT_LSB +: COPS_ALT_W];
  // per-pin alternate clocks, index 3 = pin 7
  wire [3:0] pb_clocks = {clk_src.master_oscillator_clock, clk_src.system_clock_doubled,
                          clk_src.system_clock, clk_src.prescaler_reference_clock};
  wire [3:0] pb_choice = (pb_alt & pb_clocks) | (~pb_alt & address_high);
  // gpio owns the pin unless peripheral mode is on
  assign port_b_peripheral_out = pb_choice & port_b_peripheral_enable;

  // ------------------------------------------------------------------
  // port c pins 3..0
  // ------------------------------------------------------------------
  // two-stage synchroniser for pad levels coming from outside
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_meta_reg <= 4'h0;
      pad_sync_reg <= 4'h0;
    end else begin
      pad_meta_reg <= port_c_pad_in;
      pad_sync_reg <= pad_meta_reg;
    end
  end

  wire [3:0] pc_spi = portc_sel_app_reg[3:0];
  wire [3:0] pc_per = port_c_peripheral_enable;
  // each pin steered by its own select and enable bits
  // select 1 hands the pin to spi, else timer enable decides drive
  // bit i of each bundle is pin i
  assign port_c_pad_out = pc_per & ((pc_spi & portc_drive.spi_out) |
                                    (~pc_spi & portc_drive.timer_out));
  assign port_c_pad_oe = pc_per & ((pc_spi & portc_drive.spi_oe) |
                                   (~pc_spi & portc_drive.timer_output_enable));
  // decoder only ever senses, never asks for drive
  wire [3:0] pc_dec_sel = pc_per & ~pc_spi;
  assign portc_sense.decoder_in = pc_dec_sel & pad_sync_reg;
  assign portc_sense.timer_in = pc_dec_sel & pad_sync_reg;
  // spi sees idle levels on pins it does not own
  assign portc_sense.spi_in = ((pc_per & pc_spi) & pad_sync_reg) |
                              (~(pc_per & pc_spi) & COPS_SPI_IDLE);

  // ------------------------------------------------------------------
  // peripheral clock gates
  // ------------------------------------------------------------------
  logic [15:0] gate_en_lat;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_gate
      // enable only moves while the clock is low, so no runt pulses
      // latch-based gating
      always_latch begin
        if (!core_clk) begin
          gate_en_lat[gi] = periph_clk_en_app_reg[gi];
        end
      end
      assign periph_clk[gi] = core_clk & gate_en_lat[gi];
    end
  endgenerate

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_pce_write;
    wr_pce;
  endsequence
  sequence s_pce_applied;
    ##2 (periph_clk_en_app_reg == $past(hwdata[15:0], 2));
  endsequence
  sequence s_clk_out_write;
    wr_clk_out;
  endsequence

  a_pce_write_applies: assert property (s_pce_write |-> s_pce_applied)
    else $error("peripheral clock enable not applied two edges after write");

  a_clock_pin_tristate: assert property (s_clk_out_write |->
      ##2 (clock_out_pin_oe == !$past(hwdata[COPS_DIS_BIT], 2)))
    else $error("clock pin enable does not follow disable bit");

  a_clock_sel_zero: assert property ((addr_phase && !hwrite &&
      addr_idx == COPS_IDX_CLK_OUT_SEL) |=> (hrdata[31:10] == 22'h000000))
    else $error("reserved clock select bits read nonzero");

  a_portc_write_mask: assert property (wr_portc |=>
      (portc_sel_reg == ($past(hwdata[15:0]) & COPS_PORTC_SEL_WMASK)))
    else $error("port c select write not masked");

  a_portb_gpio_prio: assert property ((port_b_peripheral_enable == 4'h0) |->
      (port_b_peripheral_out == 4'h0))
    else $error("port b peripheral output active in gpio mode");

  a_pb7_address: assert property ((port_b_peripheral_enable[3] && !pb_alt[3]) |->
      (port_b_peripheral_out[3] == address_high[3]))
    else $error("pin 7 does not carry address bit 23");

  a_pc3_timer_drive: assert property ((pc_per[3] && !pc_spi[3]) |->
      (port_c_pad_oe[3] == portc_drive.timer_output_enable[3]))
    else $error("pin c3 drive not taken from timer");

  a_pc0_spi_clock: assert property ((pc_per[0] && pc_spi[0]) |->
      (port_c_pad_out[0] == portc_drive.spi_out[0] &&
       port_c_pad_oe[0] == portc_drive.spi_oe[0]))
    else $error("pin c0 not routed to spi clock");

  a_decoder_input_only: assert property ((pc_per[2] && !pc_spi[2] &&
      !portc_drive.timer_output_enable[2]) |-> !port_c_pad_oe[2])
    else $error("decoder pin driven without timer enable");

  a_bus_zero_wait: assert property (addr_phase |=> (hreadyout && !hresp))
    else $error("slave did not answer okay at once");

  // register masks, and the applied copies two edges behind the write
  a_clock_sel_mask: assert property (wr_clk_out |=>
      (clk_out_sel_reg == ($past(hwdata[15:0]) & COPS_CLK_OUT_SEL_WMASK)))
    else $error("clock select write not masked");

  a_portc_read_zero: assert property ((addr_phase && !hwrite &&
      addr_idx == COPS_IDX_PORTC_SEL) |=> (hrdata[31:4] == 28'h0000000))
    else $error("reserved port c select bits read nonzero");

  a_source_applied: assert property (s_clk_out_write |->
      ##2 (src_code == $past(hwdata[4:0], 2)))
    else $error("clock source not applied after write");

  a_portc_applied: assert property (wr_portc |->
      ##2 (pc_spi == $past(hwdata[3:0], 2)))
    else $error("port c select not applied after write");

  // clock source map: each listed code reaches its own source
  a_source_system: assert property ((src_code == COPS_SRC_SYSTEM) |->
      (clock_output_signal == clk_src.system_clock))
    else $error("code zero does not give the system clock");

  a_source_osc: assert property ((src_code == COPS_SRC_OSC) |->
      (clock_output_signal == clk_src.master_oscillator_clock))
    else $error("oscillator code gives wrong clock");

  a_source_pll: assert property ((src_code == COPS_SRC_PLL) |->
      (clock_output_signal == clk_src.pll_output_clock))
    else $error("pll code gives wrong clock");

  a_source_conv_a: assert property ((src_code == COPS_SRC_CONV_A) |->
      (clock_output_signal == clk_src.converter_a_clock))
    else $error("first converter code gives wrong clock");

  a_source_conv_b: assert property ((src_code == COPS_SRC_CONV_B) |->
      (clock_output_signal == clk_src.converter_b_clock))
    else $error("second converter code gives wrong clock");

  a_source_test_first: assert property ((src_code == COPS_SRC_TEST_LO_FIRST) |->
      (clock_output_signal == clk_src.factory_test_clocks[0]))
    else $error("first test code gives wrong clock");

  a_source_test_last: assert property ((src_code == COPS_SRC_TEST_HI_LAST) |->
      (clock_output_signal == clk_src.factory_test_clocks[12]))
    else $error("last test code gives wrong clock");

  // port b alternate clocks while in peripheral mode
  a_pb7_oscillator: assert property ((port_b_peripheral_enable[3] && pb_alt[3]) |->
      (port_b_peripheral_out[3] == clk_src.master_oscillator_clock))
    else $error("pin 7 does not carry the oscillator");

  a_pb6_doubled: assert property ((port_b_peripheral_enable[2] && pb_alt[2]) |->
      (port_b_peripheral_out[2] == clk_src.system_clock_doubled))
    else $error("pin 6 does not carry the doubled clock");

  a_pb5_system: assert property ((port_b_peripheral_enable[1] && pb_alt[1]) |->
      (port_b_peripheral_out[1] == clk_src.system_clock))
    else $error("pin 5 does not carry the system clock");

  a_pb4_reference: assert property ((port_b_peripheral_enable[0] && pb_alt[0]) |->
      (port_b_peripheral_out[0] == clk_src.prescaler_reference_clock))
    else $error("pin 4 does not carry the reference clock");

  // port c routing, pin by pin
  a_pc3_spi_select: assert property ((pc_per[3] && pc_spi[3]) |->
      (port_c_pad_oe[3] == portc_drive.spi_oe[3]))
    else $error("pin c3 drive not taken from spi");

  a_pc2_spi_miso: assert property ((pc_per[2] && pc_spi[2]) |->
      (port_c_pad_out[2] == portc_drive.spi_out[2]))
    else $error("pin c2 level not taken from spi");

  a_pc1_timer_out: assert property ((pc_per[1] && !pc_spi[1]) |->
      (port_c_pad_out[1] == portc_drive.timer_out[1]))
    else $error("pin c1 level not taken from timer");

  a_pc0_timer_drive: assert property ((pc_per[0] && !pc_spi[0]) |->
      (port_c_pad_oe[0] == portc_drive.timer_output_enable[0]))
    else $error("pin c0 drive not taken from timer");

  a_spi_idle_select: assert property (!(pc_per[3] && pc_spi[3]) |-> portc_sense.spi_in[3])
    else $error("spi select not idle while pin not owned");

  a_portc_gpio_quiet: assert property ((pc_per == 4'h0) |->
      (port_c_pad_oe == 4'h0 && port_c_pad_out == 4'h0))
    else $error("port c driven while in gpio mode");
endmodule

// ===== cops_pkg.sv
// constants and carrier types for the clock output and pin select block
package cops_pkg;
  // register indices; the byte address on the bus is four times the index
  localparam logic [5:0] COPS_IDX_CLK_OUT_SEL = 6'h0A;
  localparam logic [5:0] COPS_IDX_PORTC_SEL = 6'h0B;
  localparam logic [5:0] COPS_IDX_PERIPH_CLK_EN = 6'h0C;
  localparam logic [7:0] COPS_ADDR_CLK_OUT_SEL = {COPS_IDX_CLK_OUT_SEL, 2'b00};
  localparam logic [7:0] COPS_ADDR_PORTC_SEL = {COPS_IDX_PORTC_SEL, 2'b00};
  localparam logic [7:0] COPS_ADDR_PERIPH_CLK_EN = {COPS_IDX_PERIPH_CLK_EN, 2'b00};
  // field positions inside the clock output select register
  localparam int COPS_SRC_LSB = 0;
  localparam int COPS_SRC_W = 5;
  localparam int COPS_DIS_BIT = 5;
  localparam int COPS_ALT_LSB = 6;
  localparam int COPS_ALT_W = 4;
  // writable bits; everything else is reserved and reads zero
  localparam logic [15:0] COPS_CLK_OUT_SEL_WMASK = 16'h03FF;
  localparam logic [15:0] COPS_PORTC_SEL_WMASK = 16'h000F;
  localparam logic [15:0] COPS_PERIPH_CLK_EN_WMASK = 16'hFFFF;
  // values after reset
  localparam logic [15:0] COPS_CLK_OUT_SEL_RST = 16'h0020;
  localparam logic [15:0] COPS_PORTC_SEL_RST = 16'h0000;
  localparam logic [15:0] COPS_PERIPH_CLK_EN_RST = 16'hFFFF;
  // clock output source codes
  localparam logic [4:0] COPS_SRC_SYSTEM = 5'h00;
  localparam logic [4:0] COPS_SRC_TEST_LO_FIRST = 5'h01;
  localparam logic [4:0] COPS_SRC_TEST_LO_LAST = 5'h06;
  localparam logic [4:0] COPS_SRC_OSC = 5'h07;
  localparam logic [4:0] COPS_SRC_PLL = 5'h08;
  localparam logic [4:0] COPS_SRC_TEST_HI_FIRST = 5'h09;
  localparam logic [4:0] COPS_SRC_TEST_HI_LAST = 5'h0F;
  localparam logic [4:0] COPS_SRC_CONV_A = 5'h10;
  localparam logic [4:0] COPS_SRC_CONV_B = 5'h11;
  localparam logic [3:0] COPS_TEST_HI_BASE = 4'h6;
  // spi inputs seen while a pin is not given to spi: slave select idle high
  localparam logic [3:0] COPS_SPI_IDLE = 4'h8;
  // ahb transfer type bit that marks an active transfer
  localparam int COPS_HTRANS_ACTIVE_BIT = 1;

  // clock sources offered to the output pin and port b
  typedef struct packed {
    logic system_clock;
    logic system_clock_doubled;
    logic master_oscillator_clock;
    logic prescaler_reference_clock;
    logic pll_output_clock;
    logic converter_a_clock;
    logic converter_b_clock;
    logic [12:0] factory_test_clocks;
  } cops_clk_src_t;

  // drive requests from the port c peripherals, index = pin number
  typedef struct packed {
    logic [3:0] timer_out;
    logic [3:0] timer_output_enable;
    logic [3:0] spi_out;
    logic [3:0] spi_oe;
  } cops_portc_drive_t;

  // pad levels handed to the port c peripherals, index = pin number
  typedef struct packed {
    logic [3:0] decoder_in;
    logic [3:0] timer_in;
    logic [3:0] spi_in;
  } cops_portc_sense_t;
endpackage

// ===== cops_far_model.sv
// far-side model: clock sources, port c peripherals and the four port c pads
`timescale 1ns/1ps
module cops_far_model
  import cops_pkg::*;
(
  // levels chosen by the bench
  input wire cops_pkg::cops_clk_src_t src_set,
  input wire cops_pkg::cops_portc_drive_t drive_set,
  input wire logic [3:0] ext_level,
  // pad side of the block
  input wire logic [3:0] port_c_pad_out,
  input wire logic [3:0] port_c_pad_oe,
  // towards the block
  output cops_pkg::cops_clk_src_t clk_src,
  output cops_pkg::cops_portc_drive_t portc_drive,
  output logic [3:0] port_c_pad_in
);
  import cops_pkg::*;
  // clock sources are held as static levels so a mux slip shows as a wrong level
  assign clk_src = src_set;
  // peripherals request drive exactly as the bench commands
  assign portc_drive = drive_set;
  // per-pin pad resolution
  // each pad sees the block where it drives, else the outside device
  assign port_c_pad_in = (port_c_pad_oe & port_c_pad_out) | (~port_c_pad_oe & ext_level);
endmodule

// ===== test_clock_output_and_pin_select.sv
// self-checking bench for the clock output and pin select block
`timescale 1ns/1ps
module test_clock_output_and_pin_select;
  import cops_pkg::*;
  // bus side
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic hready;
  logic hreadyout, hresp, clock_output_signal, clock_out_pin_oe;
  logic [31:0] hrdata;
  // far side and pins
  cops_clk_src_t src_set = '0;
  cops_clk_src_t clk_src;
  cops_portc_drive_t drive_set = '0;
  cops_portc_drive_t portc_drive;
  cops_portc_sense_t portc_sense;
  logic [3:0] port_b_peripheral_enable = 4'h0;
  logic [3:0] address_high = 4'h0;
  logic [3:0] port_c_peripheral_enable = 4'h0;
  logic [3:0] ext_level = 4'h0;
  logic [3:0] port_b_peripheral_out, port_c_pad_in, port_c_pad_out, port_c_pad_oe;
  logic [15:0] periph_clk;
  // bench bookkeeping
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #50 core_clk = ~core_clk;
  cops_top dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .clk_src(clk_src),
    .clock_output_signal(clock_output_signal), .clock_out_pin_oe(clock_out_pin_oe),
    .port_b_peripheral_enable(port_b_peripheral_enable), .address_high(address_high),
    .port_b_peripheral_out(port_b_peripheral_out),
    .port_c_peripheral_enable(port_c_peripheral_enable), .port_c_pad_in(port_c_pad_in),
    .port_c_pad_out(port_c_pad_out), .port_c_pad_oe(port_c_pad_oe),
    .portc_drive(portc_drive), .portc_sense(portc_sense), .periph_clk(periph_clk));
  cops_far_model far (.src_set(src_set), .drive_set(drive_set), .ext_level(ext_level),
    .port_c_pad_out(port_c_pad_out), .port_c_pad_oe(port_c_pad_oe), .clk_src(clk_src),
    .portc_drive(portc_drive), .port_c_pad_in(port_c_pad_in));
  // verdict and end of run, reached from the main sequence or the hang guard
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one comparison; unknown bits never count as a match
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one ahb-lite single transfer; waits on ready, the hang guard bounds it
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // write, then let the applied copy take it one edge later
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] unused;
    bus(1'b1, a, {16'h0, d}, unused);
    @(posedge core_clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk("register read", exp, r);
  endtask
  // position of each source code inside the packed source struct, -1 if none
  function automatic int src_pos(input int code);
    if (code == 0) return 19;
    if (code == 7) return 17;
    if (code == 8) return 15;
    if (code == 16) return 14;
    if (code == 17) return 13;
    if (code >= 1 && code <= 6) return code - 1;
    if (code >= 9 && code <= 15) return code - 3;
    return -1;
  endfunction
  // hang guard: the whole run needs well under this many cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    int idx;
    logic [19:0] p;
    logic [3:0] sel, en, eo, eu, pad;
    logic [15:0] pce;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    #20 chk("gated clocks", 32'h0000FFFF, 32'(periph_clk));
    chk("clock pin oe", 32'h0, 32'(clock_out_pin_oe));
    rd_chk(COPS_ADDR_CLK_OUT_SEL, 32'h00000020);
    rd_chk(COPS_ADDR_PORTC_SEL, 32'h00000000);
    rd_chk(COPS_ADDR_PERIPH_CLK_EN, 32'h0000FFFF);
    chk("bus response", 32'h0, 32'(hresp));
    chk("bus ready", 32'h1, 32'(hreadyout));
    // reserved bits hold zero, unmapped place ignores writes
    wr(COPS_ADDR_CLK_OUT_SEL, 16'hFFFF);
    rd_chk(COPS_ADDR_CLK_OUT_SEL, 32'h000003FF);
    wr(COPS_ADDR_PORTC_SEL, 16'hFFFF);
    rd_chk(COPS_ADDR_PORTC_SEL, 32'h0000000F);
    wr(8'h34, 16'h1234);
    rd_chk(8'h34, 32'h0);
    // source codes 0 to 18, each one alone high and alone low
    for (int code = 0; code < 19; code++) begin
      idx = src_pos(code);
      p = (idx < 0) ? 20'h0 : (20'h1 << idx);
      wr(COPS_ADDR_CLK_OUT_SEL, 16'(code));
      src_set <= p;
      #1 chk("clock pin oe", 32'h1, 32'(clock_out_pin_oe));
      chk("clock out high", 32'(idx >= 0), 32'(clock_output_signal));
      @(posedge core_clk);
      src_set <= ~p;
      #1 chk("clock out low", 32'h0, 32'(clock_output_signal));
    end
    wr(COPS_ADDR_CLK_OUT_SEL, 16'h0020);
    #1 chk("clock pin oe", 32'h0, 32'(clock_out_pin_oe));
    // port b: osc and system clock high, doubled and reference low
    @(posedge core_clk);
    src_set <= 20'hA0000;
    address_high <= 4'h5;
    for (int k = 0; k < 8; k++) begin
      sel = 4'(k * 5);
      en = k[2] ? 4'h5 : 4'hF;
      wr(COPS_ADDR_CLK_OUT_SEL, {6'h0, sel, 6'h20});
      port_b_peripheral_enable <= en;
      #1 chk("port b out", 32'(en & ((sel & 4'hA) | (~sel & 4'h5))),
        32'(port_b_peripheral_out));
    end
    // port c: decoder/timer against spi, pin 3 in gpio mode for the first two rounds
    @(posedge core_clk);
    drive_set <= {4'h3, 4'hA, 4'hC, 4'h6};
    ext_level <= 4'h9;
    port_c_peripheral_enable <= 4'h7;
    for (int k = 0; k < 4; k++) begin
      sel = k[0] ? 4'hA : 4'h5;
      en = k[1] ? 4'hF : 4'h7;
      wr(COPS_ADDR_PORTC_SEL, {12'h0, sel});
      port_c_peripheral_enable <= en;
      eo = en & ((sel & 4'h6) | (~sel & 4'hA));
      eu = eo & ((sel & 4'hC) | (~sel & 4'h3));
      pad = eu | (~eo & 4'h9);
      #1 chk("port c oe", 32'(eo), 32'(port_c_pad_oe));
      chk("port c out", 32'(eu), 32'(port_c_pad_out & eo));
      repeat (2) @(posedge core_clk);
      #1 chk("decoder in", 32'(pad & en & ~sel), 32'(portc_sense.decoder_in));
      chk("timer in", 32'(pad & en & ~sel), 32'(portc_sense.timer_in));
      chk("spi in", 32'((pad & en & sel) | (4'h8 & ~(en & sel))),
        32'(portc_sense.spi_in));
    end
    // peripheral clock gates follow each enable bit
    for (int k = 0; k < 2; k++) begin
      pce = k ? 16'h5A3C : 16'hA5C3;
      wr(COPS_ADDR_PERIPH_CLK_EN, pce);
      // the gate latch takes the new enable in the low phase, so look one pulse on
      @(posedge core_clk);
      #20 chk("gated clocks high", 32'(pce), 32'(periph_clk));
      #50 chk("gated clocks low", 32'h0, 32'(periph_clk));
      rd_chk(COPS_ADDR_PERIPH_CLK_EN, 32'(pce));
    end
    test_done();
  end
endmodule
